/* include/atw_map.vh */
`ifndef ATW_MAP_VH
`define ATW_MAP_VH

// Register byte addresses
`define ATW_ADDR_CTRL 8'h00
`define ATW_ADDR_FRAMES 8'h04
`define ATW_ADDR_EXPOSE 8'h08
`define ATW_ADDR_DEBOUNCE 8'h0C
`define ATW_ADDR_HEIGHT 8'h10
`define ATW_ADDR_XMIT 8'h14
`define ATW_ADDR_STATUS 8'h18
`define ATW_ADDR_IRQ_STAT 8'h1C
`define ATW_ADDR_IRQ_MASK 8'h20
`define ATW_ADDR_LINE_SEL 8'h24
`define ATW_ADDR_LINE_SRC 8'h28

// Control register fields
`define ATW_CTRL_STANDARD 0
`define ATW_CTRL_FRAME_TRIG 1
`define ATW_CTRL_DEBOUNCE_EN 2
`define ATW_CTRL_ACQ_EN 3

// Reset values
`define ATW_RST_CTRL 4'h9
`define ATW_RST_FRAMES 16'h0001
`define ATW_RST_EXPOSE 24'h0000C8
`define ATW_RST_HEIGHT 16'h01E0
`define ATW_RST_XMIT 24'h000100

// Output line choices
`define ATW_LINE_OUT1 2'h1
`define ATW_SRC_EXPOSE 2'h0
`define ATW_SRC_TRIG_WAIT 2'h1

// Interrupt bit positions
`define ATW_IRQ_ACQ_START 0
`define ATW_IRQ_EXPOSE_END 1
`define ATW_IRQ_XMIT_END 2
`define ATW_IRQ_OVERTRIG 3

// Timing in hundredths of a microsecond, clock in MHz
`define ATW_CLK_MHZ 20
`define ATW_START_DELAY_CUS 30_05
`define ATW_ROW_TIME_CUS 22_66
`define ATW_FRAME_TIME_CUS 1433_66

`endif

/* rtl/atw_frame_timer.v */
`timescale 1ns/1ns
// ----------------------------------------
// Down counter for timed phases
// ----------------------------------------
module atw_frame_timer #(
  parameter WIDTH = 32
) (
  // Clock and reset
  input wire mclk,
  input wire reset_n,
  // Control
  input wire load,
  input wire [WIDTH-1:0] count,
  // Status
  output wire busy,
  output wire done
);

  reg [WIDTH-1:0] cnt_reg;
  reg busy_reg;
  reg done_reg;

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg <= {WIDTH{1'b0}};
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (load) begin
        cnt_reg <= count;
        busy_reg <= 1'b1;
      end else if (busy_reg) begin
        if (cnt_reg <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg - {{(WIDTH-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  assign busy = busy_reg;
  assign done = done_reg;

endmodule // atw_frame_timer

/* rtl/atw_acq_ctrl.v */
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`include "atw_map.vh"
// Functional notes
// - Trigger wait status exists only in standard mode, never legacy.
// - Status goes high on entering wait-for-acquisition-start state.
// - Status goes low when an external acquisition start is accepted.
// - Acquisition starts arriving outside the wait state are ignored.
// - Output line 1 may select the trigger wait status as source.
// - Frame trigger off: internal frame starts, frame count per acquisition.
// - Trigger input is frame start in standard, acquisition start in legacy.
// - Rising trigger edge starts timed exposure lasting the exposure time; its end here also waits for a running readout to finish.
// - Exposure begins a fixed start delay after the trigger edge.
// - Enabled debounce time adds to the exposure start delay.
// - After exposure, readout of the sensor into the buffer starts.
// - Transmission starts only once enough data is buffered.
// - Readout time is (height plus one) times row time plus frame time.
// - Transmission time is payload over throughput, never below readout.
// - Height is the configured frame height; row and frame constants.
module atw_acq_ctrl #(
  parameter DELAY_CUS = `ATW_START_DELAY_CUS,
  parameter ROW_CUS = `ATW_ROW_TIME_CUS,
  parameter FRAME_CUS = `ATW_FRAME_TIME_CUS,
  parameter CLK_MHZ = `ATW_CLK_MHZ
) (
  // Clock and reset
  input wire mclk,
  input wire reset_n,
  // Register port
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output reg [31:0] rdata,
  // Trigger pins
  input wire ext_acq_start_trigger,
  input wire ext_trigger_input,
  // Camera outputs
  output wire acq_trigger_wait,
  output wire output_line1,
  output wire exposure_active,
  output wire readout_active,
  output wire transmit_active,
  output wire irq
);

  // Cycle counts, rounded up as least times
  localparam [31:0] DELAY_CYC = (DELAY_CUS * CLK_MHZ + 99) / 100;
  localparam [31:0] ROW_CYC = (ROW_CUS * CLK_MHZ + 99) / 100;
  localparam [31:0] FRAME_CYC = (FRAME_CUS * CLK_MHZ + 99) / 100;

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_WAIT = 3'h1;
  localparam [2:0] ST_FRAME = 3'h2;
  localparam [2:0] ST_DELAY = 3'h3;
  localparam [2:0] ST_EXPOSE = 3'h4;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  reg [1:0] acq_sync_reg;
  reg [1:0] trg_sync_reg;
  reg acq_last_reg;
  reg trg_last_reg;
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      acq_sync_reg <= 2'h0;
      trg_sync_reg <= 2'h0;
      acq_last_reg <= 1'b0;
      trg_last_reg <= 1'b0;
    end else begin
      acq_sync_reg <= {acq_sync_reg[0], ext_acq_start_trigger};
      trg_sync_reg <= {trg_sync_reg[0], ext_trigger_input};
      acq_last_reg <= acq_sync_reg[1];
      trg_last_reg <= trg_sync_reg[1];
    end
  end
  wire acq_rise = acq_sync_reg[1] & ~acq_last_reg;
  wire trg_rise = trg_sync_reg[1] & ~trg_last_reg;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [3:0] ctrl_reg;
  reg [15:0] frames_reg;
  reg [23:0] expose_reg;
  reg [15:0] debounce_reg;
  reg [15:0] height_reg;
  reg [23:0] xmit_reg;
  reg [3:0] irq_stat_reg;
  reg [3:0] irq_mask_reg;
  reg [1:0] line_sel_reg;
  reg [1:0] line_src_reg;
  wire standard = ctrl_reg[`ATW_CTRL_STANDARD];
  wire frame_trig_on = ctrl_reg[`ATW_CTRL_FRAME_TRIG];
  wire [3:0] irq_event;

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg <= `ATW_RST_CTRL;
      frames_reg <= `ATW_RST_FRAMES;
      expose_reg <= `ATW_RST_EXPOSE;
      debounce_reg <= 16'h0000;
      height_reg <= `ATW_RST_HEIGHT;
      xmit_reg <= `ATW_RST_XMIT;
      irq_mask_reg <= 4'h0;
      line_sel_reg <= 2'h0;
      line_src_reg <= `ATW_SRC_EXPOSE;
    end else if (wr) begin
      case (addr)
        `ATW_ADDR_CTRL: ctrl_reg <= wdata[3:0];
        `ATW_ADDR_FRAMES: frames_reg <= wdata[15:0];
        `ATW_ADDR_EXPOSE: expose_reg <= wdata[23:0];
        `ATW_ADDR_DEBOUNCE: debounce_reg <= wdata[15:0];
        `ATW_ADDR_HEIGHT: height_reg <= wdata[15:0];
        `ATW_ADDR_XMIT: xmit_reg <= wdata[23:0];
        `ATW_ADDR_IRQ_MASK: irq_mask_reg <= wdata[3:0];
        `ATW_ADDR_LINE_SEL: line_sel_reg <= wdata[1:0];
        // Source applies to the line picked by the selector
        `ATW_ADDR_LINE_SRC: begin
          if (line_sel_reg == `ATW_LINE_OUT1) begin
            line_src_reg <= wdata[1:0];
          end
        end
        default: ;
      endcase
    end
  end

  // Set wins over write-one-to-clear
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      irq_stat_reg <= 4'h0;
    end else begin
      irq_stat_reg <= (irq_stat_reg &
        ~((wr && addr == `ATW_ADDR_IRQ_STAT) ? wdata[3:0] : 4'h0))
        | irq_event;
    end
  end
  assign irq = |(irq_stat_reg & irq_mask_reg);

  // ----------------------------------------
  // Acquisition state machine
  // ----------------------------------------
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg wait_reg;
  reg [15:0] frame_cnt_reg;
  reg [15:0] frame_cnt_next;
  reg [31:0] delay_cnt_reg;
  reg [31:0] delay_cnt_next;
  reg [23:0] exp_cnt_reg;
  reg [23:0] exp_cnt_next;
  reg exp_end;
  reg accept;
  reg overtrig;

  // Debounce time in microseconds, added to the fixed delay
  wire [31:0] debounce_cyc = ctrl_reg[`ATW_CTRL_DEBOUNCE_EN] ?
    debounce_reg * CLK_MHZ : 32'h0;
  wire [31:0] total_delay = DELAY_CYC + debounce_cyc;
  // Legacy: input pin is acquisition start; standard: frame start
  wire acq_src = standard ? acq_rise : trg_rise;
  wire frame_src = standard & frame_trig_on & trg_rise;
  wire readout_busy;

  always @* begin
    state_next = state_reg;
    frame_cnt_next = frame_cnt_reg;
    delay_cnt_next = delay_cnt_reg;
    exp_cnt_next = exp_cnt_reg;
    exp_end = 1'b0;
    accept = 1'b0;
    overtrig = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (ctrl_reg[`ATW_CTRL_ACQ_EN]) begin
          state_next = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (!ctrl_reg[`ATW_CTRL_ACQ_EN]) begin
          state_next = ST_IDLE;
        end else if (acq_src) begin
          accept = 1'b1;
          frame_cnt_next = standard ? frames_reg : 16'h0001;
          // Legacy trigger edge also starts the one frame directly
          state_next = standard ? ST_FRAME : ST_DELAY;
          delay_cnt_next = total_delay;
        end
      end
      ST_FRAME: begin
        // Overlap: next exposure may start while readout runs
        if (frame_cnt_reg == 16'h0000) begin
          state_next = ST_WAIT;
        end else if (!frame_trig_on || frame_src) begin
          state_next = ST_DELAY;
          delay_cnt_next = frame_trig_on ? total_delay : 32'h1;
        end
      end
      ST_DELAY: begin
        if (delay_cnt_reg <= 32'h1) begin
          state_next = ST_EXPOSE;
          exp_cnt_next = expose_reg;
        end else begin
          delay_cnt_next = delay_cnt_reg - 32'h1;
        end
      end
      ST_EXPOSE: begin
        if (exp_cnt_reg <= 24'h1) begin
          if (!readout_busy) begin
            exp_end = 1'b1;
            frame_cnt_next = frame_cnt_reg - 16'h0001;
            state_next = standard ? ST_FRAME : ST_WAIT;
          end
        end else begin
          exp_cnt_next = exp_cnt_reg - 24'h1;
        end
      end
      default: state_next = ST_IDLE;
    endcase
    // Acquisition starts outside the wait state only raise a flag
    if (state_reg != ST_WAIT && acq_src) begin
      overtrig = 1'b1;
    end
  end

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
      wait_reg <= 1'b0;
      frame_cnt_reg <= 16'h0000;
      delay_cnt_reg <= 32'h0;
      exp_cnt_reg <= 24'h0;
    end else begin
      state_reg <= state_next;
      frame_cnt_reg <= frame_cnt_next;
      delay_cnt_reg <= delay_cnt_next;
      exp_cnt_reg <= exp_cnt_next;
      // Registered from the next state so it falls with acceptance
      wait_reg <= (state_next == ST_WAIT) & standard;
    end
  end

  assign acq_trigger_wait = wait_reg & standard;

  // ----------------------------------------
  // Readout and transmission
  // ----------------------------------------
  // Readout length: (height + 1) rows plus per-frame overhead
  wire [31:0] readout_cyc = ({16'h0, height_reg} + 32'h1) * ROW_CYC
    + FRAME_CYC;
  // Transmission never shorter than readout
  wire [31:0] xmit_req = {8'h0, xmit_reg};
  wire [31:0] xmit_cyc = (xmit_req < readout_cyc) ? readout_cyc :
    xmit_req;
  wire readout_done;
  wire xmit_busy;
  wire xmit_done;
  reg [31:0] fill_cnt_reg;
  reg xmit_go_reg;
  // Half the readout buffered keeps the drain from over- or underrunning
  wire fill_ok = fill_cnt_reg >= (readout_cyc >> 1);

  atw_frame_timer #(.WIDTH(32)) u_readout (
    .mclk(mclk),
    .reset_n(reset_n),
    .load(exp_end),
    .count(readout_cyc),
    .busy(readout_busy),
    .done(readout_done)
  );

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      fill_cnt_reg <= 32'h0;
      xmit_go_reg <= 1'b0;
    end else begin
      xmit_go_reg <= 1'b0;
      if (exp_end) begin
        fill_cnt_reg <= 32'h0;
      end else if (readout_busy && !xmit_busy) begin
        fill_cnt_reg <= fill_cnt_reg + 32'h1;
        if (fill_ok) begin
          xmit_go_reg <= 1'b1;
          fill_cnt_reg <= 32'h0;
        end
      end
    end
  end

  atw_frame_timer #(.WIDTH(32)) u_xmit (
    .mclk(mclk),
    .reset_n(reset_n),
    .load(xmit_go_reg),
    .count(xmit_cyc),
    .busy(xmit_busy),
    .done(xmit_done)
  );

  assign irq_event = {overtrig, xmit_done, exp_end, accept};

  // ----------------------------------------
  // Outputs and read port
  // ----------------------------------------
  assign exposure_active = (state_reg == ST_EXPOSE);
  assign readout_active = readout_busy;
  assign transmit_active = xmit_busy;
  assign output_line1 = (line_src_reg == `ATW_SRC_TRIG_WAIT) ?
    acq_trigger_wait : exposure_active;

  // Bit 0 flags only the parked idle state; the exposure state shares
  // its low code bits, so a two-bit compare would mislead software
  wire idle_flag = (state_reg == ST_IDLE);
  wire [31:0] status_word = {26'h0, readout_done, xmit_busy,
    readout_busy, exposure_active, acq_trigger_wait, idle_flag};

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= 32'h0;
    end else if (rd) begin
      case (addr)
        `ATW_ADDR_CTRL: rdata <= {28'h0, ctrl_reg};
        `ATW_ADDR_FRAMES: rdata <= {16'h0, frames_reg};
        `ATW_ADDR_EXPOSE: rdata <= {8'h0, expose_reg};
        `ATW_ADDR_DEBOUNCE: rdata <= {16'h0, debounce_reg};
        `ATW_ADDR_HEIGHT: rdata <= {16'h0, height_reg};
        `ATW_ADDR_XMIT: rdata <= {8'h0, xmit_reg};
        `ATW_ADDR_STATUS: rdata <= status_word;
        `ATW_ADDR_IRQ_STAT: rdata <= {28'h0, irq_stat_reg};
        `ATW_ADDR_IRQ_MASK: rdata <= {28'h0, irq_mask_reg};
        `ATW_ADDR_LINE_SEL: rdata <= {30'h0, line_sel_reg};
        `ATW_ADDR_LINE_SRC: rdata <= {30'h0, line_src_reg};
        default: rdata <= 32'h0;
      endcase
    end else begin
      rdata <= 32'h0;
    end
  end

endmodule // atw_acq_ctrl

/* tb/atw_acq_monitor.sv */
`timescale 1ns/1ns
module atw_acq_monitor (
  // Clock and reset
  input wire mclk,
  input wire reset_n,
  // Register port
  input wire wr,
  input wire rd,
  input wire [31:0] rdata,
  // Trigger pin
  input wire ext_acq_start_trigger,
  // Camera outputs
  input wire acq_trigger_wait,
  input wire output_line1,
  input wire exposure_active,
  input wire readout_active,
  input wire transmit_active,
  input wire irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // Covers the trigger sync pipeline plus slack
  logic [5:0] hist_reg;
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) hist_reg <= 6'h00;
    else hist_reg <= {hist_reg[4:0], ext_acq_start_trigger};
  end
  // A control write may end waiting one cycle later, so skip that too
  sequence quiet_s;
    !wr && !$past(wr) && !ext_acq_start_trigger && hist_reg == 6'h00;
  endsequence
  sequence exp_end_s;
    $fell(exposure_active);
  endsequence
  wait_hold_a: assert property (
    acq_trigger_wait ##0 quiet_s |=> acq_trigger_wait)
    else $error("wait status fell with no trigger");
  wait_fall_a: assert property (
    $fell(acq_trigger_wait) && !$past(wr) |->
    (hist_reg != 6'h00 || ext_acq_start_trigger))
    else $error("wait status fell without a trigger edge");
  line_src_a: assert property (
    output_line1 == acq_trigger_wait || output_line1 == exposure_active)
    else $error("line 1 source wrong");
  exp_start_a: assert property (
    $rose(exposure_active) |-> !$past(acq_trigger_wait))
    else $error("exposure began while waiting");
  readout_start_a: assert property (
    exp_end_s |-> ##[0:2] readout_active)
    else $error("readout did not follow exposure");
  xmit_start_a: assert property (
    $rose(transmit_active) |-> readout_active)
    else $error("transmit began before buffer fill");
  rd_idle_a: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data outside read slot");
  irq_hold_a: assert property (irq && !wr |=> irq)
    else $error("interrupt dropped without a clear");
endmodule // atw_acq_monitor

/* tb/atw_trig_src.sv */
`timescale 1ns/1ns
module atw_trig_src #(
  parameter int HOLD = 4
) (
  // Clock and reset
  input wire mclk,
  input wire reset_n,
  // Requests from the bench
  input wire fire_acq,
  input wire fire_frame,
  input wire obey,
  input wire wait_in,
  // Trigger pins
  output wire acq_pin,
  output wire frame_pin
);
  int cnt_a, cnt_f;
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_a <= 0;
      cnt_f <= 0;
    end else begin
      // A careful source fires only while waiting; obey low overtriggers
      if (fire_acq && (wait_in || !obey)) cnt_a <= HOLD;
      else if (cnt_a != 0) cnt_a <= cnt_a - 1;
      if (fire_frame) cnt_f <= HOLD;
      else if (cnt_f != 0) cnt_f <= cnt_f - 1;
    end
  end
  assign acq_pin = (cnt_a != 0);
  assign frame_pin = (cnt_f != 0);
endmodule // atw_trig_src

/* tb/testbench.sv */
`timescale 1ns/1ns
`include "atw_map.vh"
module testbench;
  logic mclk = 0, reset_n = 0, wr = 0, rd = 0;
  logic fire_acq = 0, fire_frame = 0, obey = 1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  wire acq_pin, frame_pin, waitst, line1, expo, rdo, xmit, irq;
  int n_errors = 0, n_checks = 0, cyc = 0;
  atw_acq_ctrl #(.DELAY_CUS(100), .ROW_CUS(100), .FRAME_CUS(100))
    atw_acq_ctrl_inst (.mclk(mclk), .reset_n(reset_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .ext_acq_start_trigger(acq_pin), .ext_trigger_input(frame_pin),
    .acq_trigger_wait(waitst), .output_line1(line1),
    .exposure_active(expo), .readout_active(rdo),
    .transmit_active(xmit), .irq(irq));
  atw_trig_src atw_trig_src_inst (.mclk(mclk), .reset_n(reset_n),
    .fire_acq(fire_acq), .fire_frame(fire_frame), .obey(obey),
    .wait_in(waitst), .acq_pin(acq_pin), .frame_pin(frame_pin));
  initial forever #25 mclk = ~mclk;
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    addr <= a; rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 check(rdata, e);
  endtask
  task automatic fire(input bit acq, input bit ob);
    @(posedge mclk);
    obey <= ob; fire_acq <= acq; fire_frame <= !acq;
    @(posedge mclk);
    fire_acq <= 1'b0; fire_frame <= 1'b0;
  endtask
  function automatic logic sel(int w);
    return w == 0 ? expo : (w == 1 ? rdo : xmit);
  endfunction
  task automatic hi_len(input int w, output int n);
    int t;
    t = 0; n = 0;
    while (sel(w) !== 1'b1 && t < 3000) begin @(negedge mclk); t++; end
    while (sel(w) === 1'b1) begin @(negedge mclk); n++; end
  endtask
  task automatic delay(output int n);
    n = 0;
    fire(0, 1);
    while (frame_pin !== 1'b1) @(negedge mclk);
    while (expo !== 1'b1 && n < 500) begin @(negedge mclk); n++; end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset;
    repeat (3) @(negedge mclk);
    check(waitst, 1'b1);
    rchk(`ATW_ADDR_CTRL, 32'h9);
    rchk(`ATW_ADDR_HEIGHT, 32'h1E0);
    rchk(8'h30, 32'h0);
    $display("test reset done");
  endtask
  task t_multi;
    int rises;
    logic prev;
    wreg(`ATW_ADDR_EXPOSE, 32'hA); wreg(`ATW_ADDR_HEIGHT, 32'h3);
    wreg(`ATW_ADDR_XMIT, 32'h5); wreg(`ATW_ADDR_FRAMES, 32'h3);
    wreg(`ATW_ADDR_IRQ_MASK, 32'h8);
    fire(1, 1);
    repeat (8) @(negedge mclk);
    check(waitst, 1'b0);
    fire(1, 0);
    // First exposure is already under way: count from the quiet level
    rises = 0;
    prev = 1'b0;
    repeat (900) begin
      @(negedge mclk);
      if (expo === 1'b1 && prev !== 1'b1) rises++;
      prev = expo;
    end
    check(32'(rises), 32'h3);
    check(waitst, 1'b1);
    check(irq, 1'b1);
    rchk(`ATW_ADDR_IRQ_STAT, 32'hF);
    wreg(`ATW_ADDR_IRQ_STAT, 32'h8);
    @(negedge mclk);
    check(irq, 1'b0);
    $display("test multi done");
  endtask
  task t_timing;
    int ne, nr, nx;
    wreg(`ATW_ADDR_FRAMES, 32'h1);
    fire(1, 1);
    fork
      hi_len(0, ne);
      hi_len(1, nr);
      hi_len(2, nx);
    join
    check(32'(ne), 32'hA);
    check(32'(nr), 32'h64);
    check(32'(nx), 32'h64);
    $display("test timing done");
  endtask
  task t_line;
    repeat (20) @(negedge mclk);
    wreg(`ATW_ADDR_LINE_SEL, 32'h0); wreg(`ATW_ADDR_LINE_SRC, 32'h1);
    @(negedge mclk);
    check(line1, 1'b0);
    wreg(`ATW_ADDR_LINE_SEL, 32'h1); wreg(`ATW_ADDR_LINE_SRC, 32'h1);
    @(negedge mclk);
    check(line1, waitst);
    check(line1, 1'b1);
    $display("test line done");
  endtask
  // Standard mode with external frame starts after the acquisition start
  task t_frametrig;
    int d, seen;
    wreg(`ATW_ADDR_CTRL, 32'hB);
    fire(1, 1);
    seen = 0;
    repeat (60) begin @(negedge mclk); seen |= expo; end
    check(32'(seen), 32'h0);
    check(waitst, 1'b0);
    delay(d);
    check(32'(d >= 20 && d <= 24), 32'h1);
    repeat (200) @(negedge mclk);
    check(waitst, 1'b1);
    $display("test frame trigger done");
  endtask
  task t_legacy;
    int d0, d1, seen;
    wreg(`ATW_ADDR_CTRL, 32'h8);
    repeat (3) @(negedge mclk);
    check(waitst, 1'b0);
    fire(1, 0);
    seen = 0;
    repeat (100) begin @(negedge mclk); seen |= expo; end
    check(32'(seen), 32'h0);
    delay(d0);
    check(32'(d0 >= 20 && d0 <= 24), 32'h1);
    repeat (400) @(negedge mclk);
    wreg(`ATW_ADDR_DEBOUNCE, 32'h2); wreg(`ATW_ADDR_CTRL, 32'hC);
    delay(d1);
    check(32'(d1 - d0), 32'h28);
    $display("test legacy done");
  endtask
  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task final_report;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Generous ceiling; the whole run needs about 2000 cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 10000) begin
      n_errors++;
      final_report;
    end
  end
  initial begin
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    t_reset;
    t_multi;
    t_timing;
    t_line;
    t_frametrig;
    t_legacy;
    final_report;
  end
endmodule // testbench
bind atw_acq_ctrl atw_acq_monitor atw_acq_monitor_inst (.mclk(mclk),
  .reset_n(reset_n), .wr(wr), .rd(rd), .rdata(rdata),
  .ext_acq_start_trigger(ext_acq_start_trigger),
  .acq_trigger_wait(acq_trigger_wait), .output_line1(output_line1),
  .exposure_active(exposure_active), .readout_active(readout_active),
  .transmit_active(transmit_active), .irq(irq));
